// *** logic/hdcal_gain_scale.sv ***
// Drive gain scaler applying the loss compensation coefficient
`timescale 1ns/1ps

module hdcal_gain_scale
	import hdcal_pkg::*;
#(
	parameter int WIDTH = 8
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Operands
	input wire logic [WIDTH-1:0] level,
	input wire logic [WIDTH-1:0] comp,
	// Scaled level, one bit wider than the input
	output logic [WIDTH:0] scaled_q
);

	// ==========================================================
	// Elaboration check
	if (WIDTH < 2 || WIDTH > 16) begin : g_bad_width
		$error("hdcal_gain_scale: WIDTH out of range");
	end

	// ==========================================================
	// Arithmetic: level * (1 + comp/255), exact division, no rounding up
	logic [2*WIDTH-1:0] prod;
	logic [2*WIDTH-1:0] quot;
	logic [WIDTH:0] scaled_d;
	assign prod = level * comp;
	assign quot = prod / (2*WIDTH)'(LOSS_COMP_DIVISOR);
	assign scaled_d = {1'b0, level} + quot[WIDTH:0];

	// Output register
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			scaled_q <= '0;
		end else begin
			scaled_q <= scaled_d;
		end
	end

endmodule

// *** logic/hdcal_pkg.sv ***
// Shared constants and carrier types for the haptic drive calibration registers
package hdcal_pkg;

	// ==========================================================
	// Register offsets
	localparam logic [7:0] ADDR_BRAKE_TIME_ADJUST = 8'h10;
	localparam logic [7:0] ADDR_NOMINAL_DRIVE_LEVEL = 8'h16;
	localparam logic [7:0] ADDR_OVERDRIVE_LIMIT_LEVEL = 8'h17;
	localparam logic [7:0] ADDR_CALIB_LOSS_COMPENSATION = 8'h18;
	localparam logic [7:0] ADDR_CALIB_BACKEMF_LEVEL = 8'h19;

	// ==========================================================
	// Reset values
	localparam logic [7:0] RST_BRAKE_TIME_ADJUST = 8'h00;
	localparam logic [7:0] RST_NOMINAL_DRIVE_LEVEL = 8'h3F;
	localparam logic [7:0] RST_OVERDRIVE_LIMIT_LEVEL = 8'h89;
	localparam logic [7:0] RST_CALIB_LOSS_COMPENSATION = 8'h0D;
	localparam logic [7:0] RST_CALIB_BACKEMF_LEVEL = 8'h6D;

	// ==========================================================
	// Timing: one brake adjustment step, and the core clock rate
	localparam int BRAKE_STEP_US = 5000;
	localparam int CORE_CLK_HZ = 125000000;
	localparam int BRAKE_STEP_CYCLES = BRAKE_STEP_US * (CORE_CLK_HZ / 1000000);

	// ==========================================================
	// Loss compensation divisor (coefficient is 1 + R/255)
	localparam int LOSS_COMP_DIVISOR = 255;

	// Field position of the feedback gain code inside the back-EMF result
	localparam int BACKEMF_GAIN_MSB = 7;
	localparam int BACKEMF_GAIN_LSB = 6;

	// ==========================================================
	// Register access request from the serial bus engine
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} hdcal_reg_req_s;

	// Result pair delivered by the calibration measurement
	typedef struct packed {
		logic valid;
		logic [7:0] loss_comp;
		logic [7:0] backemf;
	} hdcal_meas_s;

endpackage

// *** logic/hdcal_regs.sv ***
// Calibration and drive-reference register bank of the haptic driver
`timescale 1ns/1ps

// What this block does
// - The brake field is a signed count and shifts the brake segment by count times 5 ms.
// - The brake segment is the segment with the most negative drive value of the waveform.
// - The brake shift applies only in open loop and is ignored in closed loop.
// - The nominal level is the full-scale reference in closed loop; in open loop only the calibration latch (calib_nominal_q) uses it.
// - In closed loop the output is limited to nominal, or to the overdrive clamp while auto_boost is set.
// - In open loop the overdrive clamp is the full-scale reference.
// - Playback multiplies drive by 1 + R/255 using the loss compensation result R.
// - Calibration derives the loss result from the measured actuator impedance.
// - Calibration stores an 8-bit back-EMF result B worth (B/255)*1.22 V/scale setting.
// - The stored back-EMF result picks the closed-loop feedback gain.
// - Go with calibration mode starts calibration, which writes both result registers.
module hdcal_regs
	import hdcal_pkg::*;
#(
	parameter int STEP_CYCLES = BRAKE_STEP_CYCLES,
	parameter int SEG_IDX_W = 5
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Register access from the serial bus engine
	input wire hdcal_reg_req_s reg_req,
	output logic [7:0] reg_rdata_q,
	output logic reg_rvalid_q,
	// Mode and control from the control registers
	input wire logic loop_closed,
	input wire logic calib_go,
	input wire logic [1:0] backemf_scale_setting,
	// Calibration measurement
	input wire hdcal_meas_s meas,
	output logic calib_busy_q,
	output logic calib_done_q,
	output logic [7:0] calib_nominal_q,
	// Waveform segment scan
	input wire logic seg_valid,
	input wire logic seg_last,
	input wire logic signed [7:0] seg_level,
	output logic [SEG_IDX_W-1:0] brake_seg_idx_q,
	output logic brake_seg_found_q,
	output logic signed [31:0] brake_offset_cycles_q,
	// Playback drive path
	input wire logic [7:0] drive_req,
	input wire logic auto_boost,
	output logic [7:0] full_scale_ref_q,
	output logic [7:0] drive_level_q,
	output logic [8:0] drive_scaled_q,
	output logic [1:0] fb_gain_sel_q
);

	// ==========================================================
	// Elaboration checks
	if (STEP_CYCLES < 1 || STEP_CYCLES > 8000000) begin : g_bad_step
		$error("hdcal_regs: STEP_CYCLES out of range");
	end
	if (SEG_IDX_W < 1 || SEG_IDX_W > 16) begin : g_bad_idx
		$error("hdcal_regs: SEG_IDX_W out of range");
	end

	// ==========================================================
	// Register storage
	logic [7:0] brake_duration_adjust_q;
	logic [7:0] nominal_q;
	logic [7:0] overdrive_limit_level_q;
	logic [7:0] loss_comp_q;
	logic [7:0] backemf_calibration_result_q;

	typedef enum logic [1:0] {CAL_IDLE, CAL_MEASURE, CAL_STORE} hdcal_cal_e;
	hdcal_cal_e cal_q;
	hdcal_cal_e cal_d;

	// Address decode
	wire hit_brake = reg_req.addr == ADDR_BRAKE_TIME_ADJUST;
	wire hit_nom = reg_req.addr == ADDR_NOMINAL_DRIVE_LEVEL;
	wire hit_clamp = reg_req.addr == ADDR_OVERDRIVE_LIMIT_LEVEL;
	wire hit_comp = reg_req.addr == ADDR_CALIB_LOSS_COMPENSATION;
	wire hit_bemf = reg_req.addr == ADDR_CALIB_BACKEMF_LEVEL;

	// Calibration store wins over a host write in the same cycle
	wire cal_store = cal_q == CAL_STORE;
	wire [7:0] read_mux = hit_brake ? brake_duration_adjust_q :
		hit_nom ? nominal_q :
		hit_clamp ? overdrive_limit_level_q :
		hit_comp ? loss_comp_q :
		hit_bemf ? backemf_calibration_result_q : 8'h00;

	// Host-side configuration registers
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			brake_duration_adjust_q <= RST_BRAKE_TIME_ADJUST;
			nominal_q <= RST_NOMINAL_DRIVE_LEVEL;
			overdrive_limit_level_q <= RST_OVERDRIVE_LIMIT_LEVEL;
		end else if (reg_req.wr) begin
			if (hit_brake) brake_duration_adjust_q <= reg_req.wdata;
			if (hit_nom) nominal_q <= reg_req.wdata;
			if (hit_clamp) overdrive_limit_level_q <= reg_req.wdata;
		end
	end

	// Result registers: host writes persist until calibration stores
	// writable results
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			loss_comp_q <= RST_CALIB_LOSS_COMPENSATION;
			backemf_calibration_result_q <= RST_CALIB_BACKEMF_LEVEL;
		end else if (cal_store) begin
			loss_comp_q <= meas.loss_comp;
			backemf_calibration_result_q <= meas.backemf;
		end else if (reg_req.wr) begin
			if (hit_comp) loss_comp_q <= reg_req.wdata;
			if (hit_bemf) backemf_calibration_result_q <= reg_req.wdata;
		end
	end

	// Read port, unmapped addresses read zero
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			reg_rdata_q <= 8'h00;
			reg_rvalid_q <= 1'b0;
		end else begin
			reg_rdata_q <= reg_req.rd ? read_mux : reg_rdata_q;
			reg_rvalid_q <= reg_req.rd;
		end
	end

	// ==========================================================
	// Calibration sequencer
	// The measurement front end holds meas.valid only while results are good,
	// so STORE, one cycle after valid is seen, still samples those held values.
	always_comb begin
		cal_d = cal_q;
		unique case (cal_q)
			CAL_IDLE: if (calib_go) cal_d = CAL_MEASURE;
			CAL_MEASURE: if (meas.valid) cal_d = CAL_STORE;
			CAL_STORE: cal_d = CAL_IDLE;
		endcase
	end

	// Sequencer state and status; nominal level latched for the front end
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			cal_q <= CAL_IDLE;
			calib_busy_q <= 1'b0;
			calib_done_q <= 1'b0;
			calib_nominal_q <= RST_NOMINAL_DRIVE_LEVEL;
		end else begin
			cal_q <= cal_d;
			calib_busy_q <= cal_d != CAL_IDLE;
			calib_done_q <= cal_store;
			if (cal_q == CAL_IDLE && calib_go) calib_nominal_q <= nominal_q;
		end
	end

	// ==========================================================
	// Brake segment scan: strictly lower wins, so the first minimum is kept
	logic [SEG_IDX_W-1:0] seg_cnt_q;
	logic [SEG_IDX_W-1:0] min_idx_q;
	logic signed [7:0] min_lvl_q;
	logic min_any_q;
	wire first_seg = !min_any_q;
	wire new_min = seg_valid && (first_seg || seg_level < min_lvl_q);
	wire [SEG_IDX_W-1:0] cur_idx = new_min ? seg_cnt_q : min_idx_q;

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			seg_cnt_q <= '0;
			min_idx_q <= '0;
			min_lvl_q <= 8'sh00;
			min_any_q <= 1'b0;
			brake_seg_idx_q <= '0;
			brake_seg_found_q <= 1'b0;
		end else begin
			brake_seg_found_q <= seg_valid && seg_last;
			if (seg_valid && seg_last) begin
				brake_seg_idx_q <= cur_idx;
				seg_cnt_q <= '0;
				min_any_q <= 1'b0;
			end else if (seg_valid) begin
				seg_cnt_q <= seg_cnt_q + 1'b1;
				min_any_q <= 1'b1;
				if (new_min) begin
					min_idx_q <= seg_cnt_q;
					min_lvl_q <= seg_level;
				end
			end
		end
	end

	// ==========================================================
	// Brake time offset in core cycles; zero in closed loop
	wire signed [31:0] brake_cnt = 32'(signed'(brake_duration_adjust_q));
	wire signed [31:0] brake_off = brake_cnt * 32'(STEP_CYCLES);

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			brake_offset_cycles_q <= 32'sh0;
		end else begin
			// signed count of 5 ms steps
			brake_offset_cycles_q <= loop_closed ? 32'sh0 : brake_off;
		end
	end

	// ==========================================================
	// Full-scale reference and drive limit
	wire [7:0] ref_sel = loop_closed ? nominal_q : overdrive_limit_level_q;
	wire [7:0] limit = (loop_closed && !auto_boost) ? nominal_q : overdrive_limit_level_q;
	wire [7:0] limited = drive_req > limit ? limit : drive_req;

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			full_scale_ref_q <= RST_OVERDRIVE_LIMIT_LEVEL;
			drive_level_q <= 8'h00;
			fb_gain_sel_q <= 2'b00;
		end else begin
			full_scale_ref_q <= ref_sel;
			drive_level_q <= limited;
			// gain from back-EMF result; a strong return needs less gain
			// inverted result code plus the scale setting
			fb_gain_sel_q <= ~backemf_calibration_result_q[BACKEMF_GAIN_MSB:BACKEMF_GAIN_LSB]
				+ backemf_scale_setting;
		end
	end

	// Loss compensation applied to the limited drive
	// coefficient 1 + R/255
	hdcal_gain_scale #(
		.WIDTH(8)
	) u_gain (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.level(drive_level_q),
		.comp(loss_comp_q),
		.scaled_q(drive_scaled_q)
	);

endmodule

// *** test/hdcal_meas_model.sv ***
// Measurement front end model answering a calibration run
`timescale 1ns/1ps
module hdcal_meas_model
	import hdcal_pkg::*;
#(
	parameter logic [7:0] LOSS = 8'h21,
	parameter logic [7:0] BEMF = 8'hC5
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Calibration handshake
	input wire logic calib_busy_q,
	output hdcal_meas_s meas
);
	int wait_q = 0;
	initial meas = '0;
	// Results held through the store; outside a run data toggles each cycle, so stale values match only every other cycle
	// measured result pair
	always @(posedge core_clk) begin
		#1;
		wait_q <= (rst_n && calib_busy_q) ? wait_q + 1 : 0;
		if (rst_n && calib_busy_q && wait_q >= 1) begin
			meas <= '{valid: 1'b1, loss_comp: LOSS, backemf: BEMF};
		end else begin
			meas <= '{valid: 1'b0, loss_comp: ~meas.loss_comp, backemf: ~meas.backemf};
		end
	end
endmodule

// *** test/hdcal_regs_props.sv ***
// Port-level timing checks for the calibration register bank
`timescale 1ns/1ps
module hdcal_regs_props
	import hdcal_pkg::*;
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Register port
	input wire hdcal_reg_req_s reg_req,
	input wire logic reg_rvalid_q,
	// Calibration
	input wire logic calib_go,
	input wire hdcal_meas_s meas,
	input wire logic calib_busy_q,
	input wire logic calib_done_q,
	// Segment scan
	input wire logic seg_valid,
	input wire logic seg_last,
	input wire logic brake_seg_found_q,
	// Drive path
	input wire logic loop_closed,
	input wire logic [7:0] drive_req,
	input wire logic auto_boost,
	input wire logic [7:0] full_scale_ref_q,
	input wire logic [7:0] drive_level_q,
	input wire logic [8:0] drive_scaled_q,
	input wire logic signed [31:0] brake_offset_cycles_q
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	// ==========================================================
	// Store takes one cycle after results are seen, then done
	sequence store_s;
		##2 (calib_done_q && !calib_busy_q);
	endsequence
	read_answer_a: assert property (reg_req.rd |=> reg_rvalid_q)
		else $error("read not answered");
	calib_start_a: assert property (!calib_busy_q && calib_go |=> calib_busy_q)
		else $error("go did not start calibration");
	calib_store_a: assert property ($rose(calib_busy_q && meas.valid) |-> store_s)
		else $error("calibration did not finish after results");
	done_pulse_a: assert property (calib_done_q |=> !calib_done_q)
		else $error("done longer than one cycle");
	drive_limit_a: assert property ($past(rst_n) && !$past(auto_boost) |-> drive_level_q ==
		($past(drive_req) < full_scale_ref_q ? $past(drive_req) : full_scale_ref_q))
		else $error("drive level not limited by reference");
	gain_range_a: assert property ($past(rst_n) |->
		drive_scaled_q >= {1'b0, $past(drive_level_q)}
		&& drive_scaled_q <= {$past(drive_level_q), 1'b0})
		else $error("scaled drive outside coefficient range");
	seg_found_a: assert property ($past(rst_n) |->
		brake_seg_found_q == $past(seg_valid && seg_last))
		else $error("brake segment pulse misplaced");
	closed_offset_a: assert property ($past(rst_n) && $past(loop_closed) |->
		brake_offset_cycles_q == 0)
		else $error("brake offset applied in closed loop");
endmodule
bind hdcal_regs hdcal_regs_props u_props (
	.core_clk(core_clk),
	.rst_n(rst_n),
	.reg_req(reg_req),
	.reg_rvalid_q(reg_rvalid_q),
	.calib_go(calib_go),
	.meas(meas),
	.calib_busy_q(calib_busy_q),
	.calib_done_q(calib_done_q),
	.seg_valid(seg_valid),
	.seg_last(seg_last),
	.brake_seg_found_q(brake_seg_found_q),
	.loop_closed(loop_closed),
	.drive_req(drive_req),
	.auto_boost(auto_boost),
	.full_scale_ref_q(full_scale_ref_q),
	.drive_level_q(drive_level_q),
	.drive_scaled_q(drive_scaled_q),
	.brake_offset_cycles_q(brake_offset_cycles_q)
);

// *** test/testbench.sv ***
// Self-checking bench for the calibration register bank
`timescale 1ns/1ps
module testbench;
	import hdcal_pkg::*;
	logic core_clk = 0, rst_n = 0, loop_closed = 0, calib_go = 0, auto_boost = 0;
	logic seg_valid = 0, seg_last = 0, reg_rvalid_q, calib_busy_q, calib_done_q, brake_seg_found_q;
	logic [1:0] backemf_scale_setting = 2'h2;
	logic [1:0] fb_gain_sel_q;
	logic [7:0] drive_req = 8'h00;
	logic [7:0] reg_rdata_q, calib_nominal_q, full_scale_ref_q, drive_level_q;
	logic signed [7:0] seg_level = 8'h00;
	logic [4:0] brake_seg_idx_q;
	logic signed [31:0] brake_offset_cycles_q;
	logic [8:0] drive_scaled_q;
	hdcal_reg_req_s reg_req = '0;
	hdcal_meas_s meas;
	int n_fail = 0, checked = 0, cyc = 0;
	hdcal_regs #(.STEP_CYCLES(4)) uut (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.reg_req(reg_req),
		.reg_rdata_q(reg_rdata_q),
		.reg_rvalid_q(reg_rvalid_q),
		.loop_closed(loop_closed),
		.calib_go(calib_go),
		.backemf_scale_setting(backemf_scale_setting),
		.meas(meas),
		.calib_busy_q(calib_busy_q),
		.calib_done_q(calib_done_q),
		.calib_nominal_q(calib_nominal_q),
		.seg_valid(seg_valid),
		.seg_last(seg_last),
		.seg_level(seg_level),
		.brake_seg_idx_q(brake_seg_idx_q),
		.brake_seg_found_q(brake_seg_found_q),
		.brake_offset_cycles_q(brake_offset_cycles_q),
		.drive_req(drive_req),
		.auto_boost(auto_boost),
		.full_scale_ref_q(full_scale_ref_q),
		.drive_level_q(drive_level_q),
		.drive_scaled_q(drive_scaled_q),
		.fb_gain_sel_q(fb_gain_sel_q)
	);
	hdcal_meas_model partner (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.calib_busy_q(calib_busy_q),
		.meas(meas)
	);
	// ==========================================================
	// Clock, timeout and shared tasks
	initial forever #4 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 3000) begin
			n_fail++;
			wrap_up();
		end
	end
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	// Leading tick keeps two back to back strobes out of one time step
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		tick(1);
		reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		tick(1);
		reg_req.wr = 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		tick(1);
		reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		tick(1);
		reg_req.rd = 1'b0;
		chk("rvalid", 32'h1, reg_rvalid_q);
		chk("rdata", exp, reg_rdata_q);
	endtask
	// ==========================================================
	// Scenarios
	task automatic t_regs();
		logic [7:0] rv[5] = '{8'h00, 8'h3F, 8'h89, 8'h0D, 8'h6D};
		logic [7:0] ad[5] = '{8'h10, 8'h16, 8'h17, 8'h18, 8'h19};
		for (int i = 0; i < 5; i++) begin
			rd(ad[i], rv[i]);
		end
		rd(8'h11, 8'h00);
		for (int i = 0; i < 5; i++) begin
			wr(ad[i], 8'hA5 ^ rv[i]);
			rd(ad[i], 8'hA5 ^ rv[i]);
		end
	endtask
	task automatic t_brake();
		wr(8'h10, 8'hFE);
		tick(2);
		chk("offset neg", 32'hFFFFFFF8, brake_offset_cycles_q);
		wr(8'h10, 8'h03);
		tick(2);
		chk("offset pos", 32'h0000000C, brake_offset_cycles_q);
		loop_closed = 1'b1;
		tick(2);
		chk("offset closed", 32'h0, brake_offset_cycles_q);
	endtask
	task automatic t_drive();
		loop_closed = 1'b0;
		wr(8'h16, 8'h40);
		wr(8'h17, 8'h80);
		wr(8'h18, 8'hFF);
		drive_req = 8'hA0;
		tick(3);
		chk("ref open", 32'h80, full_scale_ref_q);
		chk("scaled", 32'h100, drive_scaled_q);
		loop_closed = 1'b1;
		tick(3);
		chk("ref closed", 32'h40, full_scale_ref_q);
		chk("level closed", 32'h40, drive_level_q);
		auto_boost = 1'b1;
		tick(3);
		chk("level boost", 32'h80, drive_level_q);
		loop_closed = 1'b0;
		auto_boost = 1'b0;
	endtask
	// One calibration run: program the nominal level, fire go, wait for the done pulse
	task automatic run_cal(input logic [7:0] nom);
		wr(8'h16, nom);
		calib_go = 1'b1;
		tick(1);
		calib_go = 1'b0;
		chk("busy", 32'h1, calib_busy_q);
		for (int i = 0; i < 20 && calib_done_q !== 1'b1; i++) begin
			tick(1);
		end
		chk("done", 32'h1, calib_done_q);
		chk("busy after", 32'h0, calib_busy_q);
		chk("nominal", {24'h0, nom}, calib_nominal_q);
	endtask
	// Host values persist until a run overwrites them; a new nominal level gets a rerun
	task automatic t_calib();
		wr(8'h18, 8'h33);
		rd(8'h18, 8'h33);
		run_cal(8'h55);
		rd(8'h18, 8'h21);
		rd(8'h19, 8'hC5);
		chk("fb gain", 32'h2, fb_gain_sel_q);
		backemf_scale_setting = 2'h1;
		tick(2);
		chk("fb gain scale", 32'h1, fb_gain_sel_q);
		wr(8'h19, 8'h00);
		run_cal(8'h60);
		rd(8'h19, 8'hC5);
	endtask
	// Reset in mid-run with a calibration in flight: nothing is stored, defaults return
	task automatic t_reset();
		calib_go = 1'b1;
		tick(1);
		calib_go = 1'b0;
		tick(1);
		rst_n = 1'b0;
		tick(3);
		chk("busy in reset", 32'h0, calib_busy_q);
		chk("done in reset", 32'h0, calib_done_q);
		chk("ref in reset", 32'h89, full_scale_ref_q);
		chk("nominal in reset", 32'h3F, calib_nominal_q);
		chk("offset in reset", 32'h0, brake_offset_cycles_q);
		rst_n = 1'b1;
		rd(8'h10, 8'h00);
		rd(8'h16, 8'h3F);
		rd(8'h17, 8'h89);
		rd(8'h18, 8'h0D);
		rd(8'h19, 8'h6D);
	endtask
	// Feed one waveform of n segments, lowest byte first, then judge the brake pick
	task automatic seg_wave(input logic [31:0] lv, input int n, input logic [31:0] exp);
		for (int i = 0; i < n; i++) begin
			seg_valid = 1'b1;
			seg_last = (i == n - 1);
			seg_level = lv[8*i +: 8];
			tick(1);
		end
		seg_valid = 1'b0;
		seg_last = 1'b0;
		chk("found", 32'h1, brake_seg_found_q);
		chk("index", exp, brake_seg_idx_q);
		tick(1);
	endtask
	// Plain pick, a tie that keeps the first, and a most negative last segment
	task automatic t_seg();
		seg_wave(32'h02F9FD05, 4, 32'h2);
		seg_wave(32'h00F003F0, 3, 32'h0);
		seg_wave(32'h000080F0, 2, 32'h1);
	endtask
	// Reset for three cycles, then the scenarios in turn
	initial begin
		tick(3);
		rst_n = 1'b1;
		t_regs();
		t_brake();
		t_drive();
		t_calib();
		t_reset();
		t_seg();
		wrap_up();
	end
endmodule
